// [src/tcx_pkg.sv]
// constants and carrier types for the transceiver test-control block
package tcx_pkg;

	// register offsets, unlock command and reset value on the register port
	localparam logic [7:0] OFS_ANALOG = 8'h83;
	localparam logic [7:0] OFS_DIG_A = 8'h90;
	localparam logic [7:0] OFS_DIG_B = 8'h91;
	localparam logic [7:0] OFS_MUX = 8'h92;
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] CMD_UNLOCK = 8'h0E;
	localparam logic [7:0] REG_RESET = 8'h00;

	// analog test control bits
	localparam int AN_DETECTOR_FORCE_HIGH = 7;
	localparam int AN_IF_BYPASS = 6;
	localparam int AN_FSK_IN = 2;
	localparam int AN_RSSI_TC_OFF = 1;

	// digital test control a bits
	localparam int DA_AUTOINC_OFF = 7;
	localparam int DA_CLK_KILL = 6;
	localparam int DA_XTAL_BYPASS = 5;
	localparam int DA_PAD_LSB = 3;
	localparam int DA_BIST_GO = 2;
	localparam int DA_BIST_FAIL = 1;
	localparam int DA_BIST_DONE = 0;

	// digital test control b bits
	localparam int DB_OVERDRIVE = 7;
	localparam int DB_SLOW_XTAL = 6;
	localparam int DB_KICK_CONT = 1;
	localparam int DB_KICK_CLAMP = 0;

	// pad test field codes
	localparam logic [1:0] PAD_NORMAL = 2'h0;
	localparam logic [1:0] PAD_TEST_B = 2'h1;
	localparam logic [1:0] PAD_TEST_A = 2'h2;
	localparam logic [1:0] PAD_PULLUP = 2'h3;

	// upper probe select codes
	localparam logic [3:0] UP_NORMAL = 4'h0;
	localparam logic [3:0] UP_SD_CLK = 4'h2;
	localparam logic [3:0] UP_SAMPLE = 4'h4;
	localparam logic [3:0] UP_AM_FILT = 4'h5;
	localparam logic [3:0] UP_LATCH = 4'h6;
	localparam logic [3:0] UP_ONESHOT = 4'h7;
	localparam logic [3:0] UP_PLL_REF = 4'h8;
	localparam logic [3:0] UP_LOCKED = 4'h9;
	localparam logic [3:0] UP_LOCKFAIL = 4'hA;
	localparam logic [3:0] UP_WOP = 4'hB;
	localparam logic [3:0] UP_CDR = 4'hC;
	localparam logic [3:0] UP_KICKER = 4'hD;
	localparam logic [3:0] UP_XTAL = 4'hE;

	// lower probe select codes
	localparam logic [3:0] LO_NORMAL = 4'h0;
	localparam logic [3:0] LO_SLOW_RC = 4'h4;
	localparam logic [3:0] LO_COMP = 4'h7;
	localparam logic [3:0] LO_SD_OUT = 4'h8;
	localparam logic [3:0] LO_DIV160 = 4'hA;
	localparam logic [3:0] LO_DIV512 = 4'hB;
	localparam logic [3:0] LO_DIV2000 = 4'hC;
	localparam logic [3:0] LO_DIV10000 = 4'hD;
	localparam logic [3:0] LO_KICK_DONE = 4'hE;
	localparam logic [3:0] LO_CKSUM = 4'hF;

	// divider ratios in source clock periods
	localparam int DIV_160 = 160;
	localparam int DIV_512 = 512;
	localparam int DIV_2000 = 2000;
	localparam int DIV_10000 = 10000;

	// byte-level register port from the serial interface
	typedef struct packed {
		logic xfer_start;
		logic [7:0] xfer_addr;
		logic wr_stb;
		logic rd_stb;
		logic [7:0] wdata;
	} tcx_regport_s;

	// internal signals offered to the probe multiplexer
	typedef struct packed {
		logic normal_upper;
		logic sigma_delta_clk;
		logic sample_clk;
		logic am_filter_clk;
		logic latch_clk;
		logic one_shot;
		logic pll_reference_divided_clock;
		logic pll_locked;
		logic pll_lock_failed;
		logic wake_pattern_start;
		logic cdr_start;
		logic kicker;
		logic xtal_clk;
		logic normal_lower;
		logic slow_rc_clock;
		logic comparator_out;
		logic sigma_delta_output;
		logic kick_cycle_finished;
		logic checksum_failed;
	} tcx_probe_src_s;

endpackage

// [src/tcx_tick_div.sv]
// divides a tick stream into a square wave for the probe
`timescale 1ns/100ps
`default_nettype none
module tcx_tick_div #(
	parameter int DIV = 160
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	output logic div_out
);
	localparam int HALF = DIV / 2;
	localparam int CW = $clog2(HALF);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic q;
	} tcx_div_s;

	tcx_div_s div_reg;
	tcx_div_s div_next;

	always_comb begin
		div_next = div_reg;
		if (tick) begin
			if (div_reg.cnt == CW'(HALF - 1)) begin
				div_next.cnt = '0;
				div_next.q = ~div_reg.q;
			end else begin
				div_next.cnt = div_reg.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	assign div_out = div_reg.q;
endmodule // tcx_tick_div
`default_nettype wire

// [src/tcx_test_ctrl.sv]
// test-control registers, test mode outputs and clock probe multiplexer
`timescale 1ns/100ps
`default_nettype none
module tcx_test_ctrl #(
	parameter int RC_DIV = tcx_pkg::DIV_10000
) (
	input wire logic clk,
	input wire logic rst,
	input wire tcx_pkg::tcx_regport_s reg_port,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic irq_request,
	input wire logic irq_pin_i,
	output logic irq_pin_o,
	output logic irq_pin_oe,
	output logic fsk_test_input,
	output logic detector_force_high,
	output logic if_filter_bypass,
	output logic rssi_tempcomp_off,
	output logic digital_clock_enable,
	output logic crystal_bypass,
	input wire logic crystal_input_pad,
	input wire logic xtal_tick,
	input wire logic rc_tick,
	output logic [1:0] pad_test_sel,
	output logic pullups_disabled,
	output logic eeprom_selftest_go,
	input wire logic eeprom_bist_done_i,
	input wire logic eeprom_bist_fail_i,
	input wire logic am_gpio_i,
	input wire logic fm_gpio_i,
	input wire logic am_slice_i,
	input wire logic fm_slice_i,
	output logic gpio_oe,
	output logic cdr_am_data,
	output logic cdr_fm_data,
	output logic slow_clock_as_xtal,
	output logic kick_continuous,
	output logic kick_clamped,
	input wire tcx_pkg::tcx_probe_src_s probe_src,
	output logic probe_upper_out,
	output logic probe_lower_out
);
	typedef struct packed {
		logic [7:0] ana;
		logic [7:0] dig_a;
		logic [7:0] dig_b;
		logic [7:0] mux;
		logic [7:0] ptr;
		logic unlock;
		logic [7:0] rdata;
		logic rvalid;
		logic go;
		logic irq_o;
		logic fsk_in;
		logic cdr_am;
		logic cdr_fm;
		logic up;
		logic lo;
		logic oe_irq;
		logic clk_en;
		logic pull_off;
		logic oe_gpio;
	} tcx_state_s;

	tcx_state_s state_reg;
	tcx_state_s state_next;

	logic src_tick;
	logic div160;
	logic div512;
	logic div2000;
	logic div10000;
	logic [3:0] clock_probe_upper_select;
	logic [3:0] probe_lower_select;

	function automatic logic [7:0] reg_read(input logic [7:0] a, input tcx_state_s st);
		logic [7:0] v;
		v = 8'h00;
		if (a == tcx_pkg::OFS_ANALOG) v = st.ana;
		else if (a == tcx_pkg::OFS_DIG_A) v = st.dig_a;
		else if (a == tcx_pkg::OFS_DIG_B) v = st.dig_b;
		else if (a == tcx_pkg::OFS_MUX) v = st.mux;
		return v;
	endfunction

	function automatic logic [7:0] ptr_step(input logic [7:0] p, input logic hold);
		return hold ? p : p + 8'h01;
	endfunction

	assign src_tick = state_reg.dig_a[tcx_pkg::DA_XTAL_BYPASS] ? crystal_input_pad :
		(state_reg.dig_b[tcx_pkg::DB_SLOW_XTAL] ? rc_tick : xtal_tick);

	tcx_tick_div #(.DIV(tcx_pkg::DIV_160)) u_div160 (
		.clk(clk), .rst(rst), .tick(src_tick), .div_out(div160));
	tcx_tick_div #(.DIV(tcx_pkg::DIV_512)) u_div512 (
		.clk(clk), .rst(rst), .tick(src_tick), .div_out(div512));
	tcx_tick_div #(.DIV(tcx_pkg::DIV_2000)) u_div2000 (
		.clk(clk), .rst(rst), .tick(src_tick), .div_out(div2000));
	tcx_tick_div #(.DIV(RC_DIV)) u_div10000 (
		.clk(clk), .rst(rst), .tick(rc_tick), .div_out(div10000));

	assign clock_probe_upper_select = state_reg.mux[7:4];
	assign probe_lower_select = state_reg.mux[3:0];

	always_comb begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		state_next.go = 1'b0;
		if (reg_port.xfer_start) begin
			state_next.ptr = reg_port.xfer_addr;
		end else if (reg_port.wr_stb) begin
			if (state_reg.ptr == tcx_pkg::OFS_ANALOG) begin
				state_next.ana = reg_port.wdata;
			end else if (state_reg.ptr == tcx_pkg::OFS_DIG_A) begin
				state_next.dig_a[7:2] = reg_port.wdata[7:2];
				if (reg_port.wdata[tcx_pkg::DA_BIST_GO]) begin
					state_next.go = 1'b1;
					state_next.dig_a[1:0] = 2'h0;
				end
			end else if (state_reg.ptr == tcx_pkg::OFS_DIG_B) begin
				state_next.dig_b[7:2] = reg_port.wdata[7:2];
				if (state_reg.unlock) begin
					state_next.dig_b[1:0] = reg_port.wdata[1:0];
				end
				state_next.unlock = 1'b0;
			end else if (state_reg.ptr == tcx_pkg::OFS_MUX) begin
				state_next.mux = reg_port.wdata;
			end else if (state_reg.ptr == tcx_pkg::OFS_CMD) begin
				state_next.unlock = (reg_port.wdata == tcx_pkg::CMD_UNLOCK);
			end
			state_next.ptr = ptr_step(state_reg.ptr, state_reg.dig_a[tcx_pkg::DA_AUTOINC_OFF]);
		end else if (reg_port.rd_stb) begin
			state_next.rdata = reg_read(state_reg.ptr, state_reg);
			state_next.rvalid = 1'b1;
			state_next.ptr = ptr_step(state_reg.ptr, state_reg.dig_a[tcx_pkg::DA_AUTOINC_OFF]);
		end
		if (eeprom_bist_fail_i) begin
			state_next.dig_a[tcx_pkg::DA_BIST_FAIL] = 1'b1;
		end
		if (eeprom_bist_done_i) begin
			state_next.dig_a[tcx_pkg::DA_BIST_DONE] = 1'b1;
		end
		state_next.irq_o = irq_request;
		state_next.fsk_in = state_reg.ana[tcx_pkg::AN_FSK_IN] & irq_pin_i;
		state_next.cdr_am = state_reg.dig_b[tcx_pkg::DB_OVERDRIVE] ? am_gpio_i : am_slice_i;
		state_next.cdr_fm = state_reg.dig_b[tcx_pkg::DB_OVERDRIVE] ? fm_gpio_i : fm_slice_i;
		state_next.oe_irq = ~state_next.ana[tcx_pkg::AN_FSK_IN];
		state_next.clk_en = ~state_next.dig_a[tcx_pkg::DA_CLK_KILL];
		state_next.pull_off = state_next.dig_a[tcx_pkg::DA_PAD_LSB +: 2] == tcx_pkg::PAD_TEST_A
			|| state_next.dig_a[tcx_pkg::DA_PAD_LSB +: 2] == tcx_pkg::PAD_TEST_B;
		state_next.oe_gpio = ~state_next.dig_b[tcx_pkg::DB_OVERDRIVE];
		unique case (clock_probe_upper_select)
			tcx_pkg::UP_NORMAL: state_next.up = probe_src.normal_upper;
			tcx_pkg::UP_SD_CLK: state_next.up = probe_src.sigma_delta_clk;
			tcx_pkg::UP_SAMPLE: state_next.up = probe_src.sample_clk;
			tcx_pkg::UP_AM_FILT: state_next.up = probe_src.am_filter_clk;
			tcx_pkg::UP_LATCH: state_next.up = probe_src.latch_clk;
			tcx_pkg::UP_ONESHOT: state_next.up = probe_src.one_shot;
			tcx_pkg::UP_PLL_REF: state_next.up = probe_src.pll_reference_divided_clock;
			tcx_pkg::UP_LOCKED: state_next.up = probe_src.pll_locked;
			tcx_pkg::UP_LOCKFAIL: state_next.up = probe_src.pll_lock_failed;
			tcx_pkg::UP_WOP: state_next.up = probe_src.wake_pattern_start;
			tcx_pkg::UP_CDR: state_next.up = probe_src.cdr_start;
			tcx_pkg::UP_KICKER: state_next.up = probe_src.kicker;
			tcx_pkg::UP_XTAL: state_next.up = probe_src.xtal_clk;
			default: state_next.up = 1'b0;
		endcase
		unique case (probe_lower_select)
			tcx_pkg::LO_NORMAL: state_next.lo = probe_src.normal_lower;
			tcx_pkg::LO_SLOW_RC: state_next.lo = probe_src.slow_rc_clock;
			tcx_pkg::LO_COMP: state_next.lo = probe_src.comparator_out;
			tcx_pkg::LO_SD_OUT: state_next.lo = probe_src.sigma_delta_output;
			tcx_pkg::LO_KICK_DONE: state_next.lo = probe_src.kick_cycle_finished;
			tcx_pkg::LO_DIV160: state_next.lo = div160;
			tcx_pkg::LO_DIV512: state_next.lo = div512;
			tcx_pkg::LO_DIV2000: state_next.lo = div2000;
			tcx_pkg::LO_DIV10000: state_next.lo = div10000;
			tcx_pkg::LO_CKSUM: state_next.lo = probe_src.checksum_failed;
			default: state_next.lo = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.ana <= tcx_pkg::REG_RESET;
			state_reg.dig_a <= tcx_pkg::REG_RESET;
			state_reg.dig_b <= tcx_pkg::REG_RESET;
			state_reg.mux <= tcx_pkg::REG_RESET;
			state_reg.oe_irq <= 1'b1;
			state_reg.clk_en <= 1'b1;
			state_reg.oe_gpio <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data = state_reg.rdata;
	assign rd_valid = state_reg.rvalid;
	assign irq_pin_o = state_reg.irq_o;
	assign irq_pin_oe = state_reg.oe_irq;
	assign fsk_test_input = state_reg.fsk_in;
	assign detector_force_high = state_reg.ana[tcx_pkg::AN_DETECTOR_FORCE_HIGH];
	assign if_filter_bypass = state_reg.ana[tcx_pkg::AN_IF_BYPASS];
	assign rssi_tempcomp_off = state_reg.ana[tcx_pkg::AN_RSSI_TC_OFF];
	assign digital_clock_enable = state_reg.clk_en;
	assign crystal_bypass = state_reg.dig_a[tcx_pkg::DA_XTAL_BYPASS];
	assign pad_test_sel = state_reg.dig_a[tcx_pkg::DA_PAD_LSB +: 2];
	assign pullups_disabled = state_reg.pull_off;
	assign eeprom_selftest_go = state_reg.go;
	assign gpio_oe = state_reg.oe_gpio;
	assign cdr_am_data = state_reg.cdr_am;
	assign cdr_fm_data = state_reg.cdr_fm;
	assign slow_clock_as_xtal = state_reg.dig_b[tcx_pkg::DB_SLOW_XTAL];
	assign kick_continuous = state_reg.dig_b[tcx_pkg::DB_KICK_CONT];
	assign kick_clamped = state_reg.dig_b[tcx_pkg::DB_KICK_CLAMP];
	assign probe_upper_out = state_reg.up;
	assign probe_lower_out = state_reg.lo;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic wr_any;
	assign wr_any = reg_port.wr_stb && !reg_port.xfer_start;

	chk_detector_force_high_set: assert property (
		wr_any && state_reg.ptr == tcx_pkg::OFS_ANALOG && reg_port.wdata[7] |=> detector_force_high)
		else $error("detector_force_high not forced");
	chk_filter_bypass: assert property (
		wr_any && state_reg.ptr == tcx_pkg::OFS_ANALOG |=> if_filter_bypass == $past(reg_port.wdata[6]))
		else $error("filter bypass wrong");
	chk_irq_pin_input: assert property (
		state_reg.ana[2] && $stable(state_reg.ana) |-> !irq_pin_oe ##1 fsk_test_input == $past(irq_pin_i))
		else $error("interrupt pin not taken as input");
	chk_autoinc_hold: assert property (
		wr_any && state_reg.dig_a[7] |=> $stable(state_reg.ptr))
		else $error("pointer advanced while held");
	chk_autoinc_step: assert property (
		reg_port.rd_stb && !reg_port.wr_stb && !reg_port.xfer_start && !state_reg.dig_a[7]
		|=> state_reg.ptr == $past(state_reg.ptr) + 8'h01 && rd_valid)
		else $error("pointer did not advance");
	chk_clock_gate: assert property (
		wr_any && state_reg.ptr == tcx_pkg::OFS_DIG_A |=> digital_clock_enable == !$past(reg_port.wdata[6]))
		else $error("clock gate wrong");
	chk_pad_pullups: assert property (
		pad_test_sel == tcx_pkg::PAD_PULLUP || pad_test_sel == tcx_pkg::PAD_NORMAL |-> !pullups_disabled)
		else $error("pull-ups disabled wrongly");
	chk_bist_go_pulse: assert property (
		wr_any && state_reg.ptr == tcx_pkg::OFS_DIG_A && reg_port.wdata[2] |=> eeprom_selftest_go ##1 !eeprom_selftest_go)
		else $error("self test start not a single pulse");
	chk_bist_fail_sticky: assert property (
		eeprom_bist_fail_i |=> state_reg.dig_a[1] [*2] or (state_reg.dig_a[1] ##1 eeprom_selftest_go))
		else $error("failure flag lost");
	chk_bist_done_set: assert property (
		eeprom_bist_done_i |=> state_reg.dig_a[0])
		else $error("finished flag not set");
	chk_unlock_guard: assert property (
		wr_any && state_reg.ptr == tcx_pkg::OFS_DIG_B && !state_reg.unlock
		|=> kick_clamped == $past(kick_clamped) && kick_continuous == $past(kick_continuous))
		else $error("kicker bits written while locked");
	chk_overdrive_path: assert property (
		state_reg.dig_b[7] |-> !gpio_oe ##1 cdr_am_data == $past(am_gpio_i)
		&& cdr_fm_data == $past(fm_gpio_i))
		else $error("override data wrong");
	chk_slow_xtal_mode: assert property (
		wr_any && state_reg.ptr == tcx_pkg::OFS_DIG_B |=> slow_clock_as_xtal == $past(reg_port.wdata[6]))
		else $error("slow oscillator mode wrong");
	chk_kick_unlocked_write: assert property (
		wr_any && state_reg.ptr == tcx_pkg::OFS_DIG_B && state_reg.unlock
		|=> {kick_continuous, kick_clamped} == $past(reg_port.wdata[1:0]))
		else $error("kicker modes not written");
	chk_upper_pllref: assert property (
		clock_probe_upper_select == tcx_pkg::UP_PLL_REF
		|=> probe_upper_out == $past(probe_src.pll_reference_divided_clock))
		else $error("upper probe wrong");
	chk_upper_oneshot: assert property (
		clock_probe_upper_select == tcx_pkg::UP_ONESHOT |=> probe_upper_out == $past(probe_src.one_shot))
		else $error("one-shot probe wrong");
	chk_lower_comparator: assert property (
		probe_lower_select == tcx_pkg::LO_COMP |=> probe_lower_out == $past(probe_src.comparator_out))
		else $error("comparator probe wrong");
	chk_lower_unused: assert property (
		probe_lower_select inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h9} |=> !probe_lower_out)
		else $error("unassigned lower code not low");

	cov_bist_fail: cover property (eeprom_selftest_go ##[1:50] state_reg.dig_a[1]);
	cov_unlock_write: cover property (state_reg.unlock && wr_any && state_reg.ptr == tcx_pkg::OFS_DIG_B);
	cov_div160_toggle: cover property (probe_lower_select == tcx_pkg::LO_DIV160 && $rose(probe_lower_out));
	cov_autoinc_off: cover property (state_reg.dig_a[7] && reg_port.rd_stb);
endmodule // tcx_test_ctrl
`default_nettype wire

// [bench/tcx_bist_model.sv]
// eeprom self-test engine stand-in answering the start pulse
`timescale 1ns/100ps
`default_nettype none
module tcx_bist_model #(
	parameter int DLY = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic fail_mode,
	output logic done,
	output logic fail,
	output int n_go
);
	int cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			done <= 1'b0;
			fail <= 1'b0;
			n_go <= 0;
		end else begin
			done <= 1'b0;
			fail <= 1'b0;
			if (go) begin
				cnt <= DLY;
				n_go <= n_go + 1;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					done <= 1'b1;
					fail <= fail_mode;
				end
			end
		end
	end
endmodule // tcx_bist_model
`default_nettype wire

// [bench/transceiver_test_control_tb.sv]
// self-checking bench for the test-control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module transceiver_test_control_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	tcx_pkg::tcx_regport_s rp = '0;
	tcx_pkg::tcx_probe_src_s src = '0;
	logic [7:0] rd_data;
	logic rd_valid, irq_req = 1'b0, ext_irq = 1'b0, irq_o, irq_oe, fsk_in, det_hi, if_byp;
	logic rssi_off, dce, xbyp, pad = 1'b0, xt = 1'b0, rc = 1'b0, pulloff, go, done, fail;
	logic [1:0] pad_sel;
	logic am_g = 1'b0, fm_g = 1'b0, am_s = 1'b0, fm_s = 1'b0, gpio_oe, cdr_am, cdr_fm;
	logic slow_x, k_cont, k_clamp, p_up, p_lo, fail_mode = 1'b0;
	wire logic irq_pin = irq_oe ? irq_o : ext_irq;
	int fails = 0, n_tests = 0, cyc = 0, n_go;
	int upi[16] = '{18, -1, 17, -1, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, -1};
	int loi[16] = '{5, -1, -1, -1, 4, -1, -1, 3, 2, -1, -2, -2, -2, -2, 1, 0};

	tcx_test_ctrl #(.RC_DIV(20)) i_dut (.clk(clk), .rst(rst), .reg_port(rp), .rd_data(rd_data),
		.rd_valid(rd_valid), .irq_request(irq_req), .irq_pin_i(irq_pin), .irq_pin_o(irq_o),
		.irq_pin_oe(irq_oe), .fsk_test_input(fsk_in), .detector_force_high(det_hi),
		.if_filter_bypass(if_byp), .rssi_tempcomp_off(rssi_off), .digital_clock_enable(dce),
		.crystal_bypass(xbyp), .crystal_input_pad(pad), .xtal_tick(xt), .rc_tick(rc),
		.pad_test_sel(pad_sel), .pullups_disabled(pulloff), .eeprom_selftest_go(go),
		.eeprom_bist_done_i(done), .eeprom_bist_fail_i(fail), .am_gpio_i(am_g),
		.fm_gpio_i(fm_g), .am_slice_i(am_s), .fm_slice_i(fm_s), .gpio_oe(gpio_oe),
		.cdr_am_data(cdr_am), .cdr_fm_data(cdr_fm), .slow_clock_as_xtal(slow_x),
		.kick_continuous(k_cont), .kick_clamped(k_clamp), .probe_src(src),
		.probe_upper_out(p_up), .probe_lower_out(p_lo));

	tcx_bist_model #(.DLY(4)) i_bist (.clk(clk), .rst(rst), .go(go), .fail_mode(fail_mode),
		.done(done), .fail(fail), .n_go(n_go));

	initial begin
		forever #4 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic xfer(input logic [7:0] a);
		step();
		rp = '{1'b1, a, 1'b0, 1'b0, 8'h00};
	endtask

	task automatic wb(input logic [7:0] d);
		step();
		rp = '{1'b0, 8'h00, 1'b1, 1'b0, d};
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a);
		wb(d);
		step();
		rp = '0;
		step();
	endtask

	task automatic rb(input logic [7:0] e);
		step();
		rp = '{1'b0, 8'h00, 1'b0, 1'b1, 8'h00};
		step();
		rp = '0;
		`CHK(rd_valid, 1'b1)
		`CHK(rd_data, e)
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(a);
		rb(e);
	endtask

	// reset values and unmapped read
	task automatic t_reset();
		foreach (upi[i]) begin
			if (i < 4) rd(i == 0 ? 8'h83 : 8'h8F + 8'(i), 8'h00);
		end
		rd(8'h50, 8'h00);
		`CHK({irq_oe, dce, gpio_oe, det_hi, xbyp}, 5'h1C)
	endtask

	task automatic t_analog();
		irq_req = 1'b1;
		ext_irq = 1'b1;
		wr(8'h83, 8'hC6);
		`CHK({det_hi, if_byp, rssi_off, irq_oe, fsk_in}, 5'h1D)
		ext_irq = 1'b0;
		step();
		step();
		`CHK(fsk_in, 1'b0)
		rd(8'h83, 8'hC6);
		wr(8'h83, 8'h00);
		`CHK({det_hi, if_byp, irq_oe, irq_pin}, 4'h3)
	endtask

	task automatic t_autoinc();
		wr(8'h90, 8'h80);
		xfer(8'h91);
		wb(8'h40);
		wb(8'h44);
		step();
		rp = '0;
		rd(8'h91, 8'h44);
		rd(8'h92, 8'h00);
		wr(8'h90, 8'h00);
		xfer(8'h91);
		wb(8'h40);
		wb(8'h33);
		step();
		rp = '0;
		step();
		`CHK(slow_x, 1'b1)
		xfer(8'h91);
		rb(8'h40);
		rb(8'h33);
		wr(8'h92, 8'h00);
		wr(8'h91, 8'h00);
		`CHK(slow_x, 1'b0)
	endtask

	task automatic t_modes_a();
		wr(8'h90, 8'h60);
		`CHK({dce, xbyp}, 2'h1)
		for (int p = 0; p < 4; p++) begin
			wr(8'h90, 8'(p << 3));
			`CHK({pad_sel, pulloff, dce, xbyp}, {2'(p), p == 1 || p == 2, 2'h2})
		end
		wr(8'h90, 8'h00);
	endtask

	task automatic t_bist();
		for (int f = 0; f < 2; f++) begin
			fail_mode = f[0];
			wr(8'h90, 8'h04);
			`CHK(n_go, f + 1)
			repeat (8) step();
			rd(8'h90, f ? 8'h07 : 8'h05);
		end
		wr(8'h90, 8'h00);
		rd(8'h90, 8'h03);
	endtask

	task automatic t_modes_b();
		wr(8'h91, 8'h03);
		rd(8'h91, 8'h00);
		wr(8'h00, 8'h0E);
		wr(8'h91, 8'h03);
		`CHK({k_cont, k_clamp}, 2'h3)
		wr(8'h91, 8'h00);
		rd(8'h91, 8'h03);
		wr(8'h00, 8'h0E);
		wr(8'h91, 8'h80);
		{am_g, fm_g, am_s, fm_s} = 4'h9;
		step();
		step();
		`CHK({gpio_oe, cdr_am, cdr_fm, k_cont}, 4'h4)
		wr(8'h91, 8'h00);
		`CHK({gpio_oe, cdr_am, cdr_fm}, 3'h5)
	endtask

	task automatic mux_chk(input int c, input int idx, input logic up);
		wr(8'h92, {4'(c), 4'(c)});
		for (int ph = 0; ph < 2; ph++) begin
			src = (idx < 0) ? '1 : (ph == 0 ? 19'(1) << idx : ~(19'(1) << idx));
			step();
			step();
			`CHK(up ? p_up : p_lo, idx >= 0 && ph == 0)
		end
	endtask

	task automatic t_mux();
		for (int c = 0; c < 16; c++) begin
			mux_chk(c, upi[c], 1'b1);
			if (loi[c] > -2) mux_chk(c, loi[c], 1'b0);
		end
	endtask

	task automatic div(input logic [7:0] a, input logic [7:0] m, input int n, input int e);
		int k;
		logic prev;
		k = 0;
		wr(8'h90, a);
		wr(8'h92, m);
		repeat (50) step();
		prev = p_lo;
		repeat (n) begin
			step();
			if (p_lo && !prev) k++;
			prev = p_lo;
		end
		`CHK(k, e)
	endtask

	task automatic t_div();
		xt = 1'b1;
		div(8'h00, 8'h0A, 1600, 10);
		div(8'h00, 8'h0C, 4000, 2);
		{xt, pad} = 2'h1;
		div(8'h20, 8'h0A, 1600, 10);
		{pad, rc} = 2'h1;
		wr(8'h91, 8'h40);
		div(8'h00, 8'h0B, 5120, 10);
		div(8'h00, 8'h0D, 200, 10);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_analog();
		t_autoinc();
		t_modes_a();
		t_bist();
		t_modes_b();
		t_mux();
		t_div();
		tally_and_finish();
	end
endmodule // transceiver_test_control_tb
`default_nettype wire
